// File: common/cdc_seq_pkg.sv
// Constants, carriers and state layout of the measurement sequencer.
// Assumes a 50 MHz system clock and a two-wire bus master outside.
package cdc_seq_pkg;
  // Bus identity and timing
  localparam logic [6:0] SLAVE_ADDR    = 7'h50;
  localparam int         CLK_KHZ       = 50000;
  localparam int         SCL_MIN_KHZ   = 10;
  localparam int         SCL_MAX_KHZ   = 400;
  localparam int         SCL_MIN_CYC   = (CLK_KHZ + SCL_MAX_KHZ - 1) / SCL_MAX_KHZ;
  localparam int         SYNC_MARGIN   = 8;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  // Pointer map
  localparam logic [7:0] PTR_RESET     = 8'h00;
  localparam logic [7:0] PTR_RES_LAST  = 8'h07;
  localparam logic [7:0] PTR_CFG_FIRST = 8'h08;
  localparam logic [7:0] PTR_CFG_LAST  = 8'h0b;
  localparam logic [7:0] PTR_CTRL      = 8'h0c;
  // Slot configuration word
  localparam logic [15:0] CFG_RESET    = 16'h1c00;
  localparam logic [15:0] CFG_MASK     = 16'hffe0;
  localparam int          CFG_POS_LSB  = 13;
  localparam int          CFG_NEG_LSB  = 10;
  localparam int          CFG_DAC_LSB  = 5;
  localparam logic [2:0]  NEG_DAC      = 3'h4;
  localparam logic [2:0]  NEG_OFF      = 3'h7;
  localparam logic [9:0]  DAC_STEP     = 10'h019;
  // Control word
  localparam int          CTRL_RATE_LSB = 10;
  localparam int          CTRL_RPT_BIT  = 8;
  localparam int          CTRL_TRIG_LSB = 4;
  localparam int          CTRL_DONE_LSB = 0;
  localparam logic [7:0]  RES_PAD       = 8'h00;
  localparam int          NUM_SLOTS     = 4;

  // Bus phase, one-hot
  typedef enum logic [4:0] {
    PH_IDLE = 5'b00001,
    PH_RX   = 5'b00010,
    PH_ACK  = 5'b00100,
    PH_TX   = 5'b01000,
    PH_MACK = 5'b10000
  } phase_t;

  // Request to the analog front end
  typedef struct packed {
    logic       start;
    logic [1:0] slot;
    logic [2:0] pos;
    logic [2:0] neg;
    logic       diff;
    logic       dac_en;
    logic [4:0] dac_code;
    logic [9:0] offset_125ff;
    logic [1:0] first_shield_output;
    logic [1:0] second_shield_output;
    logic       second_shield_output_en;
    logic       shld_short;
    logic [1:0] rate;
  } conv_req_t;

  // Whole state of the block
  typedef struct packed {
    logic              scl_s1, scl_s2, scl_p;
    logic              sda_s1, sda_s2, sda_p;
    phase_t            ph;
    logic [3:0]        cnt;
    logic [7:0]        sh;
    logic [1:0]        byte_n;
    logic              rw, hi_sel, mack_ok, sda_oe;
    logic [7:0]        wr_hi;
    logic [15:0]       tx_word;
    logic [7:0]        ptr;
    logic [3:0][15:0]  cfg;
    logic [1:0]        rate;
    logic              rpt;
    logic [3:0]        trig, done, half;
    logic [3:0][23:0]  res;
    logic [3:0][7:0]   hold;
    logic              busy;
    logic [1:0]        cur;
    conv_req_t         conv;
  } state_t;

  localparam state_t RESET_STATE = '{
    scl_s1: 1'b1, scl_s2: 1'b1, scl_p: 1'b1,
    sda_s1: 1'b1, sda_s2: 1'b1, sda_p: 1'b1,
    ph: PH_IDLE, ptr: PTR_RESET, cfg: {4{CFG_RESET}},
    default: '0};
endpackage : cdc_seq_pkg

// File: src/cdc_i2c_measurement_sequencer.sv
// Two-wire slave, register file and conversion sequencer.
// Assumes SCL/SDA arrive asynchronously and a front end on clk answers
// each start with one conv_done pulse carrying a 24-bit result.
//
// Function
// - Negative select below 4 means differential
// - Differential conversions keep offset DAC off
// - Shields go lower then higher channel
// - Answer only slave address 0x50
// - Bus 10 to 400 kHz, MSB first
// - First written byte loads the pointer
// - Reads use stored pointer, never change it
// - Pointer-only write then repeated-start read works
// - Words move upper byte then lower byte
// - Writes to read-only registers get NACK
// - Unused pointer value gets NACK
// - Foreign address: no ACK, ignore frame
// - Four independent slot configurations
// - Single mode: one trigger, one conversion
// - Repeat mode restarts every enabled slot
// - Completion sets the slot done flag
// - Result pairs at result1_upper..result4_lower, upper first
// - Reading both halves clears done flag
// - Repeat continues until repeat bit cleared
// - Select 4 or 7 means single-ended
// - Pointer resets to result1_upper
// - Offset is code times 3.125 pF
`timescale 1ns/1ps
`default_nettype none

module cdc_i2c_measurement_sequencer
  import cdc_seq_pkg::*;
#(
  parameter int SLOTS = NUM_SLOTS  // Measurement slots
) (
  input  wire logic        clk,          // System clock
  input  wire logic        rst,          // Synchronous reset
  input  wire logic        scl,          // Bus clock level
  input  wire logic        sda,          // Bus data level
  output logic             sda_drv,      // Value while driving
  output logic             sda_oe,       // High pulls SDA low
  output var conv_req_t    conv,         // Front-end request
  input  wire logic        conv_done,    // Front-end finished
  input  wire logic [23:0] conv_result   // Front-end result
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  ////////////////////////////////////////////////////////////////////////
  if (SLOTS != NUM_SLOTS) begin : g_bad_slots
    $error("Only four slots are supported");
  end
  if (SCL_MIN_CYC / 2 < SYNC_MARGIN) begin : g_bad_rate
    $error("Clock too slow for the fastest bus rate");
  end

  ////////////////////////////////////////////////////////////////////////
  // Helper functions
  ////////////////////////////////////////////////////////////////////////
  // Pointer names an implemented register
  function automatic logic reg_ok(input logic [7:0] p);
    return p <= PTR_CTRL;
  endfunction : reg_ok

  // Pointer names a writable register
  function automatic logic reg_wr(input logic [7:0] p);
    return p >= PTR_CFG_FIRST && p <= PTR_CTRL;
  endfunction : reg_wr

  // Next triggered slot after c, cyclic; bit 2 flags a hit
  function automatic logic [2:0] next_slot(input logic [3:0] t,
                                           input logic [1:0] c);
    logic [2:0] r;
    logic [1:0] k;
    r = 3'h0;
    for (int i = 4; i >= 1; i--) begin
      k = c + 2'(i);
      if (t[k]) begin
        r = {1'b1, k};
      end
    end
    return r;
  endfunction : next_slot

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////////////////
  state_t      q;          // Registered state
  state_t      d;          // Next state
  logic        bus_rise;   // SCL rising edge
  logic        bus_fall;   // SCL falling edge
  logic        bus_start;  // Start or repeated start
  logic        bus_stop;   // Stop condition
  logic        rx_done;    // Eighth bit of a received byte ended
  logic [2:0]  pick;       // Slot chosen for the next conversion
  logic [15:0] pick_cfg;   // Configuration of that slot
  logic [15:0] rd_word;    // Word addressed by the pointer
  logic [15:0] wr_word;    // Word completed by the current byte
  logic [1:0]  rd_slot;    // Result slot addressed by the pointer
  logic        load_hi;    // Fetch word, send upper byte
  logic        load_lo;    // Send lower byte
  logic [3:0]  done_set;   // Conversions finished this cycle
  logic [3:0]  done_clr;   // Result pairs read this cycle
  logic [2:0]  neg_sel;    // Negative select of picked slot
  logic [2:0]  pos_sel;    // Positive select of picked slot

  ////////////////////////////////////////////////////////////////////////
  // Edge and condition decode on synchronised levels
  ////////////////////////////////////////////////////////////////////////
  assign bus_rise  = q.scl_s2 & ~q.scl_p;
  assign bus_fall  = ~q.scl_s2 & q.scl_p;
  // Start also covers the repeated start of a pointer-then-read frame
  assign bus_start = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
  assign bus_stop  = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;
  assign rx_done   = (q.ph == PH_RX) & bus_fall & (q.cnt == BYTE_BITS);
  assign pick      = next_slot(q.trig, q.cur);
  assign pick_cfg  = q.cfg[pick[1:0]];
  assign pos_sel   = pick_cfg[CFG_POS_LSB +: 3];
  assign neg_sel   = pick_cfg[CFG_NEG_LSB +: 3];
  assign rd_slot   = q.ptr[2:1];
  assign wr_word   = {q.wr_hi, q.sh};

  // Register read mux; results are upper word at even pointers
  always_comb begin
    rd_word = 16'h0000;
    if (q.ptr <= PTR_RES_LAST) begin
      if (!q.ptr[0]) begin
        rd_word = q.res[rd_slot][23:8];
      end else if (q.half[rd_slot]) begin
        rd_word = {q.hold[rd_slot], RES_PAD};
      end else begin
        rd_word = {q.res[rd_slot][7:0], RES_PAD};
      end
    end else if (q.ptr <= PTR_CFG_LAST) begin
      rd_word = q.cfg[q.ptr[1:0]] & CFG_MASK;
    end else if (q.ptr == PTR_CTRL) begin
      rd_word[CTRL_RATE_LSB +: 2] = q.rate;
      rd_word[CTRL_RPT_BIT]       = q.rpt;
      rd_word[CTRL_TRIG_LSB +: 4] = q.trig;
      rd_word[CTRL_DONE_LSB +: 4] = q.done;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    d          = q;
    load_hi    = 1'b0;
    load_lo    = 1'b0;
    done_set   = 4'h0;
    done_clr   = 4'h0;
    d.conv.start = 1'b0;

    // Two-stage synchronisers plus history stage
    d.scl_s1 = scl;
    d.scl_s2 = q.scl_s1;
    d.scl_p  = q.scl_s2;
    d.sda_s1 = sda;
    d.sda_s2 = q.sda_s1;
    d.sda_p  = q.sda_s2;

    // Sequencer: wait for the front end, then pick the next slot
    if (q.busy) begin
      if (conv_done) begin
        d.res[q.cur]      = conv_result;
        done_set[q.cur]   = 1'b1;
        d.busy            = 1'b0;
        // Single shot drops its trigger; repeat keeps it armed
        if (!q.rpt) begin
          d.trig[q.cur] = 1'b0;
        end
      end
    end else if (pick[2]) begin
      // Repeat mode re-arms every triggered slot in turn
      d.busy        = 1'b1;
      d.cur         = pick[1:0];
      d.conv.start  = 1'b1;
      d.conv.slot   = pick[1:0];
      d.conv.rate   = q.rate;
      d.conv.pos    = pos_sel;
      d.conv.neg    = neg_sel;
      d.conv.diff   = neg_sel < NEG_DAC;
      d.conv.dac_en = neg_sel == NEG_DAC;
      if (neg_sel < NEG_DAC) begin
        // Offset DAC forced off whatever its field says
        d.conv.dac_en       = 1'b0;
        d.conv.dac_code     = 5'h00;
        d.conv.offset_125ff = 10'h000;
        // Lower channel on first shield; selects never equal
        d.conv.first_shield_output = (pos_sel < neg_sel) ? pos_sel[1:0] : neg_sel[1:0];
        d.conv.second_shield_output = (pos_sel < neg_sel) ? neg_sel[1:0] : pos_sel[1:0];
        d.conv.second_shield_output_en   = 1'b1;
        d.conv.shld_short = 1'b0;
      end else begin
        // Single-ended on the positive input
        d.conv.dac_code     = (neg_sel == NEG_DAC) ? pick_cfg[CFG_DAC_LSB +: 5] : 5'h00;
        d.conv.offset_125ff = (neg_sel == NEG_DAC) ?
                              10'(pick_cfg[CFG_DAC_LSB +: 5]) * DAC_STEP : 10'h000;
        d.conv.first_shield_output      = pos_sel[1:0];
        d.conv.second_shield_output      = pos_sel[1:0];
        // Shorted shields without DAC, second floats with DAC
        d.conv.second_shield_output_en   = neg_sel != NEG_DAC;
        d.conv.shld_short = neg_sel != NEG_DAC;
      end
    end

    // Bus engine
    if (bus_start) begin
      d.ph     = PH_RX;
      d.cnt    = 4'h0;
      d.byte_n = 2'h0;
      d.sda_oe = 1'b0;
    end else if (bus_stop) begin
      d.ph     = PH_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      unique case (q.ph)
        // Waiting for a start
        PH_IDLE: begin
        end
        // Receiving a byte, MSB first
        PH_RX: begin
          if (bus_rise) begin
            d.sh  = {q.sh[6:0], q.sda_s2};
            d.cnt = q.cnt + 4'h1;
          end else if (rx_done) begin
            d.ph     = PH_ACK;
            d.sda_oe = 1'b1;
            d.byte_n = (q.byte_n == 2'h2) ? 2'h2 : q.byte_n + 2'h1;
            unique case (q.byte_n)
              // Address byte: seven bits then direction
              2'h0: begin
                if (q.sh[7:1] == SLAVE_ADDR) begin
                  d.rw     = q.sh[0];
                  d.hi_sel = 1'b0;
                end else begin
                  d.ph     = PH_IDLE;
                  d.sda_oe = 1'b0;
                end
              end
              // Pointer byte of a write
              2'h1: begin
                d.hi_sel = 1'b0;
                if (reg_ok(q.sh)) begin
                  d.ptr = q.sh;
                end else begin
                  d.ph     = PH_IDLE;
                  d.sda_oe = 1'b0;
                end
              end
              // Data bytes, upper then lower
              default: begin
                if (!reg_wr(q.ptr)) begin
                  d.ph     = PH_IDLE;
                  d.sda_oe = 1'b0;
                end else if (!q.hi_sel) begin
                  d.wr_hi  = q.sh;
                  d.hi_sel = 1'b1;
                end else begin
                  d.hi_sel = 1'b0;
                  if (q.ptr == PTR_CTRL) begin
                    d.rate = wr_word[CTRL_RATE_LSB +: 2];
                    d.rpt  = wr_word[CTRL_RPT_BIT];
                    d.trig = wr_word[CTRL_TRIG_LSB +: 4];
                  end else begin
                    d.cfg[q.ptr[1:0]] = wr_word & CFG_MASK;
                  end
                end
              end
            endcase
          end
        end
        // Holding our acknowledge for one bit
        PH_ACK: begin
          if (bus_fall) begin
            d.sda_oe = 1'b0;
            d.cnt    = 4'h0;
            if (q.rw) begin
              d.ph    = PH_TX;
              load_hi = 1'b1;
            end else begin
              d.ph = PH_RX;
            end
          end
        end
        // Sending a byte; bits change only while SCL is low
        PH_TX: begin
          if (bus_rise) begin
            d.cnt = q.cnt + 4'h1;
          end else if (bus_fall) begin
            if (q.cnt == BYTE_BITS) begin
              d.sda_oe = 1'b0;
              d.ph     = PH_MACK;
            end else begin
              d.sh     = {q.sh[6:0], 1'b0};
              d.sda_oe = ~q.sh[6];
            end
          end
        end
        // Master acknowledge decides whether reading continues
        PH_MACK: begin
          if (bus_rise) begin
            d.mack_ok = ~q.sda_s2;
          end else if (bus_fall) begin
            if (q.mack_ok) begin
              d.ph    = PH_TX;
              d.cnt   = 4'h0;
              load_lo = q.hi_sel;
              load_hi = ~q.hi_sel;
            end else begin
              d.ph = PH_IDLE;
            end
          end
        end
      endcase
    end

    // Word fetch; pointer is only read here
    if (load_hi) begin
      d.tx_word = rd_word;
      d.sh      = rd_word[15:8];
      d.sda_oe  = ~rd_word[15];
      d.hi_sel  = 1'b1;
      // Upper half read: freeze the matching lower bits
      if (q.ptr <= PTR_RES_LAST && !q.ptr[0]) begin
        d.hold[rd_slot] = q.res[rd_slot][7:0];
        d.half[rd_slot] = 1'b1;
      end
    end
    if (load_lo) begin
      d.sh     = q.tx_word[7:0];
      d.sda_oe = ~q.tx_word[7];
      d.hi_sel = 1'b0;
      if (q.ptr <= PTR_RES_LAST && q.ptr[0] && q.half[rd_slot]) begin
        d.half[rd_slot]   = 1'b0;
        done_clr[rd_slot] = 1'b1;
      end
    end

    // A completion in the same cycle beats the clear
    d.done = (q.done & ~done_clr) | done_set;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state; sda_drv tied low
  assign sda_drv = 1'b0;
  assign sda_oe  = q.sda_oe;
  assign conv    = q.conv;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  addr_ack_a: assert property (
    rx_done && q.byte_n == 2'h0 && q.sh[7:1] == SLAVE_ADDR
    |=> q.sda_oe && q.ph == PH_ACK)
    else $error("Own address not acknowledged");

  addr_nack_a: assert property (
    rx_done && q.byte_n == 2'h0 && q.sh[7:1] != SLAVE_ADDR
    |=> !q.sda_oe && q.ph == PH_IDLE)
    else $error("Foreign address acknowledged");

  ptr_nack_a: assert property (
    rx_done && q.byte_n == 2'h1 && !reg_ok(q.sh)
    |=> !q.sda_oe && $stable(q.ptr))
    else $error("Unused pointer acknowledged");

  ro_nack_a: assert property (
    rx_done && q.byte_n == 2'h2 && !reg_wr(q.ptr)
    // Only a finishing conversion may move a result, never the bus
    |=> !q.sda_oe && ($stable(q.res) || $past(q.busy && conv_done)))
    else $error("Read-only write acknowledged");

  ptr_reset_a: assert property (disable iff (1'b0)
    rst |=> q.ptr == PTR_RESET)
    else $error("Pointer not cleared by reset");

  read_ptr_a: assert property (
    q.rw && q.ph != PH_IDLE |=> $stable(q.ptr))
    else $error("Pointer moved during a read");

  diff_dac_a: assert property (
    q.conv.start |-> q.conv.diff == (q.conv.neg < NEG_DAC)
                     && (!q.conv.diff || (!q.conv.dac_en && q.conv.dac_code == 5'h00)))
    else $error("Differential decode or DAC wrong");

  shield_a: assert property (
    q.conv.start && q.conv.diff |-> q.conv.first_shield_output < q.conv.second_shield_output
      && (q.conv.first_shield_output == q.conv.pos[1:0] || q.conv.first_shield_output == q.conv.neg[1:0]))
    else $error("Shield order wrong");

  single_a: assert property (
    q.conv.start && (q.conv.neg == NEG_DAC || q.conv.neg == NEG_OFF)
    |-> !q.conv.diff && q.conv.first_shield_output == q.conv.pos[1:0])
    else $error("Single-ended decode wrong");

  done_set_a: assert property (
    q.busy && conv_done |=> q.done[$past(q.cur)] && !q.busy)
    else $error("Done flag not set");

  restart_a: assert property (
    (q.busy && conv_done && q.rpt) ##1 (|q.trig && !q.busy)
    |=> q.conv.start && q.busy)
    else $error("Repeat mode did not restart");

  addr_seen_c:  cover property (rx_done && q.byte_n == 2'h0 && q.sh[7:1] == SLAVE_ADDR);
  ptr_write_c:  cover property (rx_done && q.byte_n == 2'h1 && reg_ok(q.sh));
  done_clear_c: cover property (|done_clr);
  repeat_c:     cover property (q.rpt && q.conv.start ##[1:1000] q.conv.start);

endmodule : cdc_i2c_measurement_sequencer

`default_nettype wire

// File: testbench/fe_model.sv
// Behavioural analog front end that answers each conversion request.
// Assumes the request fields stay steady from their start pulse on.
`timescale 1ns/1ps
`default_nettype none

module fe_model
  import cdc_seq_pkg::*;
#(
  parameter int LAT = 12  // Cycles from start to done
) (
  input  wire logic        clk,         // System clock
  input  wire logic        rst,         // Synchronous reset
  input  var  conv_req_t   conv,        // Request from the sequencer
  output logic             conv_done,   // One-cycle completion pulse
  output logic [23:0]      conv_result  // Result, valid with done only
);
  logic [4:0]  cnt_q = 5'h00;  // Cycles left
  logic [15:0] seq_q = 16'h0000;  // Results handed out so far

  initial conv_done = 1'b0;
  initial conv_result = 24'h000000;

  ////////////////////////////////////////////////////////////////////////////
  // Count down, then pulse done with a result tagged by slot and sequence
  always @(posedge clk) begin
    conv_done <= 1'b0;
    conv_result <= ~conv_result;  // Stale value is not held
    if (rst) begin
      cnt_q <= 5'h00;
    end else if (conv.start) begin
      cnt_q <= 5'(LAT);
    end else if (cnt_q == 5'h01) begin
      cnt_q <= 5'h00;
      conv_done <= 1'b1;
      conv_result <= {2'h2, conv.slot, 4'h5, seq_q};
      seq_q <= seq_q + 16'h0001;
    end else if (cnt_q != 5'h00) begin
      cnt_q <= cnt_q - 5'h01;
    end
  end
endmodule : fe_model

`default_nettype wire

// File: testbench/cdc_i2c_measurement_sequencer_tb.sv
// Self-checking bench: a two-wire master drives register frames.
// Assumes the front end model answers each request after a short delay.
`timescale 1ns/1ps
`default_nettype none

module cdc_i2c_measurement_sequencer_tb
  import cdc_seq_pkg::*;
;
  localparam logic [7:0] A_W = 8'ha0;  // Own address, write
  logic        clk = 1'b0;   // System clock
  logic        rst = 1'b1;   // Reset, held at start
  logic        scl = 1'b1;   // Bus clock, still between frames
  logic        m_low = 1'b0; // Master pulls SDA low
  logic        sda_drv;      // Device drive value
  logic        sda_oe;       // Device pulls SDA low
  wire         sda_w;        // Resolved open-drain line
  conv_req_t   conv;         // Request to the front end
  logic        conv_done;    // Front end completion
  logic [23:0] conv_result;  // Front end result
  logic [23:0] res_exp [4];  // Last result per slot
  conv_req_t   req_q;        // Last request seen
  int          nstart = 0;   // Requests seen
  int          n0;           // Request count mark
  int          bad_count = 0;
  int          comparisons = 0;
  int          cyc = 0;      // Cycles run
  logic [3:0]  nk;           // Per byte, high = NACK
  logic [15:0] v;            // Word read back
  logic [15:0] cfgv [4] = '{16'h40a0, 16'h33e0, 16'h7c60, 16'h0c00};
  logic [5:0]  ev [4] = '{6'h0a, 6'h01, 6'h00, 6'h0e};  // Shields, diff, DAC

  assign sda_w = ~(m_low | (sda_oe & ~sda_drv));

  cdc_i2c_measurement_sequencer #(.SLOTS(4)) i_dut (
    .clk(clk), .rst(rst), .scl(scl), .sda(sda_w), .sda_drv(sda_drv),
    .sda_oe(sda_oe), .conv(conv), .conv_done(conv_done), .conv_result(conv_result));
  fe_model i_fe (.clk(clk), .rst(rst), .conv(conv), .conv_done(conv_done),
    .conv_result(conv_result));

  initial begin
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watch requests and results, cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (conv_done) begin
      res_exp[conv.slot] <= conv_result;
    end
    if (conv.start) begin
      req_q <= conv;
      nstart <= nstart + 1;
    end
    if (cyc == 60000) begin
      bad_count++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // One bit: data mid-low, sample late in the high phase
  task automatic bit_x(input logic b, output logic got);
    tick(2);
    m_low = ~b;
    tick(2);
    scl = 1'b1;
    tick(4);
    got = sda_w;
    scl = 1'b0;
  endtask : bit_x

  task automatic byte_x(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
                        output logic nak);
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
    bit_x(ak, nak);
  endtask : byte_x

  task automatic start_c();
    tick(6);
    m_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    m_low = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask : start_c

  task automatic stop_c();
    tick(2);
    m_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    m_low = 1'b0;
    tick(8);
  endtask : stop_c

  // Address, pointer, one word
  task automatic wr(input logic [7:0] a, input logic [7:0] p, input logic [15:0] d);
    logic [7:0] rx;
    start_c();
    byte_x(a, 1'b1, rx, nk[0]);
    byte_x(p, 1'b1, rx, nk[1]);
    byte_x(d[15:8], 1'b1, rx, nk[2]);
    byte_x(d[7:0], 1'b1, rx, nk[3]);
    stop_c();
  endtask : wr

  // Optional pointer write, repeated start, read one word
  task automatic rd(input logic [8:0] p, output logic [15:0] d);
    logic [7:0] rx;
    logic       k;
    if (!p[8]) begin
      start_c();
      byte_x(A_W, 1'b1, rx, nk[0]);
      byte_x(p[7:0], 1'b1, rx, nk[1]);
    end
    start_c();
    byte_x(A_W | 8'h01, 1'b1, rx, nk[2]);
    chk(nk[2], 1'b0);
    byte_x(8'hff, 1'b0, d[15:8], k);
    byte_x(8'hff, 1'b1, d[7:0], k);
    stop_c();
  endtask : rd

  task automatic report_and_stop();
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    tick(2);
    rst = 1'b0;
    tick(6);
    rd(9'h100, v);
    chk(v, 16'h0000);
    for (int p = 0; p <= 12; p++) begin
      rd({1'b0, 8'(p)}, v);
      chk(v, (p >= 8 && p <= 11) ? CFG_RESET : 16'h0000);
    end
    // One single conversion per slot: differential, DAC, single-ended, differential
    for (int s = 0; s < 4; s++) begin
      wr(A_W, 8'h08 + 8'(s), cfgv[s] | 16'h001f);
      chk(nk, 4'h0);
      rd({1'b0, 8'h08 + 8'(s)}, v);
      chk(v, cfgv[s]);
      rd(9'h100, v);
      chk(v, cfgv[s]);
      n0 = nstart;
      wr(A_W, PTR_CTRL, 16'h0010 << s);
      rd({1'b0, PTR_CTRL}, v);
      chk(v, 16'h0001 << s);
      rd({1'b0, 8'(2 * s)}, v);
      chk(v, res_exp[s][23:8]);
      rd({1'b0, 8'(2 * s + 1)}, v);
      chk(v, {res_exp[s][7:0], 8'h00});
      rd({1'b0, PTR_CTRL}, v);
      chk(v, 16'h0000);
      chk(nstart, n0 + 1);
      chk(req_q.slot, s);
      chk({req_q.pos, req_q.neg}, cfgv[s][15:10]);
      chk({req_q.diff, req_q.dac_en}, ev[s][1:0]);
      if (ev[s][1]) begin
        chk({req_q.first_shield_output, req_q.second_shield_output}, ev[s][5:2]);
      end else if (ev[s][0]) begin
        chk({req_q.offset_125ff, req_q.second_shield_output_en}, {10'h307, 1'b0});
        chk(req_q.dac_code, cfgv[s][9:5]);
      end else begin
        chk(req_q.shld_short, 1'b1);
      end
    end
    // Refused frames leave registers alone; a read-only write still moves the pointer
    rd({1'b0, 8'h08}, v);
    wr(8'ha2, 8'h08, 16'h1234);
    chk(nk, 4'hf);
    wr(A_W, 8'h0d, 16'h1234);
    chk(nk, 4'he);
    rd(9'h100, v);
    chk(v, cfgv[0]);
    wr(A_W, 8'h02, 16'hffff);
    chk(nk, 4'hc);
    rd(9'h100, v);
    chk(v, res_exp[1][23:8]);
    // Repeat mode on two slots at rate code 1, no reads, then stop
    n0 = nstart;
    wr(A_W, PTR_CTRL, 16'h0530);
    for (int i = 0; i < 2000 && nstart < n0 + 8; i++) begin
      tick(1);
    end
    rd({1'b0, PTR_CTRL}, v);
    chk(v, 16'h0533);
    chk(req_q.rate, 2'h1);
    chk(nstart >= n0 + 8, 1'b1);
    wr(A_W, PTR_CTRL, 16'h0000);
    tick(20);
    n0 = nstart;
    tick(300);
    chk(nstart, n0);
    report_and_stop();
  end
endmodule : cdc_i2c_measurement_sequencer_tb

`default_nettype wire
